// ### shared/dxbus_defines.svh
// Constants of the external memory bus interface: timing counts and reset values.
`ifndef DXBUS_DEFINES_SVH
`define DXBUS_DEFINES_SVH
`define DXBUS_ADDR_W 16
`define DXBUS_DATA_W 16
`define DXBUS_WAIT_W 3
`define DXBUS_WAIT_MAX 3'h7
`define DXBUS_GLOBAL_MSB 15
`define DXBUS_ADDR_RST 16'h0000
`define DXBUS_DATA_RST 16'h0000
`define DXBUS_SPACE_PROG 2'h0
`define DXBUS_SPACE_DATA 2'h1
`define DXBUS_SPACE_IO 2'h2
`endif

// ### shared/dxbus_pkg.sv
// Types shared by the external memory bus interface.
`default_nettype none
package dxbus_pkg;
  typedef enum logic [1:0] {
    DXBUS_SP_PROG,
    DXBUS_SP_DATA,
    DXBUS_SP_IO,
    DXBUS_SP_GLOBAL
  } dxbus_space_t;
  typedef enum logic [2:0] {
    DXBUS_ST_IDLE,
    DXBUS_ST_SETUP,
    DXBUS_ST_WAIT,
    DXBUS_ST_READY,
    DXBUS_ST_HOLD
  } dxbus_state_t;
endpackage : dxbus_pkg
`default_nettype wire

// ### hdl/dxbus_waitcfg.sv
// Per-space wait-state configuration store with registered lookup.
`default_nettype none
`include "dxbus_defines.svh"
module dxbus_waitcfg #(
  parameter int WAIT_W = `DXBUS_WAIT_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [1:0] wr_space_i,
  input wire logic [WAIT_W-1:0] wr_count_i,
  input wire logic [1:0] rd_space_i,
  output logic [WAIT_W-1:0] rd_count_o
);
  // ************************************************************
  // Storage
  // ************************************************************
  logic [WAIT_W-1:0] cfg_ff [4];
  logic [WAIT_W-1:0] rd_count_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        cfg_ff[i] <= '0;
      end
      rd_count_ff <= '0;
    end else begin
      if (wr_en_i) begin
        cfg_ff[wr_space_i] <= wr_count_i;
      end
      rd_count_ff <= cfg_ff[rd_space_i];
    end
  end

  assign rd_count_o = rd_count_ff;
endmodule // dxbus_waitcfg
`default_nettype wire

// ### hdl/dxbus_master.sv
// External bus master of the signal processor: spaces, strobes, wait states and float control.
// Operation
// - Separate 64K program, data, I/O spaces plus 32K global data space, one bus.
// - Software sets zero to seven wait states per space, stretching each access.
// - Sixteen-bit two-way data bus, bit 15 most significant, shared by all spaces.
// - Data bus floats unless writing, and always during reset.
// - Address driven on address outputs for every off-chip access.
// - Program select high, low only during off-chip program access.
// - Data select high, low only during off-chip data access.
// - I/O select high, low only during I/O port access.
// - Ready sampled; low means wait one more cycle and sample again.
// - Direction line high by default, low only during writes.
// - Active-low read strobe asserted on every external read.
// - Active-low write strobe on every write; falling edge means data driven.
// - Float input low tri-states data, address and all control outputs.
// - Bus-cycle strobe high, low only to mark an external cycle.
// - Float only when test reset low, emulator pin zero high, float pin low.
`default_nettype none
`include "dxbus_defines.svh"
module dxbus_master
  import dxbus_pkg::*;
#(
  parameter int ADDR_W = `DXBUS_ADDR_W,
  parameter int DATA_W = `DXBUS_DATA_W,
  parameter int WAIT_W = `DXBUS_WAIT_W
) (
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic WAIT_WR_I,
  input wire dxbus_pkg::dxbus_space_t WAIT_SPACE_I,
  input wire logic [WAIT_W-1:0] WAIT_COUNT_I,
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic REQ_WRITE_I,
  input wire dxbus_pkg::dxbus_space_t REQ_SPACE_I,
  input wire logic [ADDR_W-1:0] REQ_ADDR_I,
  input wire logic [DATA_W-1:0] REQ_WDATA_I,
  output logic RSP_VALID_O,
  output logic [DATA_W-1:0] RSP_RDATA_O,
  output logic [ADDR_W-1:0] ADDRESS_BUS_O,
  output logic ADDRESS_BUS_OE_O,
  input wire logic [DATA_W-1:0] DATA_BUS_I,
  output logic [DATA_W-1:0] DATA_BUS_O,
  output logic DATA_BUS_OE_O,
  output logic PROGRAM_SPACE_SELECT_N_O,
  output logic DATA_SPACE_SELECT_N_O,
  output logic IO_SPACE_SELECT_N_O,
  output logic BUS_CYCLE_STROBE_N_O,
  output logic READ_WRITE_O,
  output logic READ_STROBE_N_O,
  output logic WRITE_STROBE_N_O,
  output logic CONTROL_OE_O,
  input wire logic READY_I,
  input wire logic TEST_RESET_I,
  input wire logic EMULATOR_PIN_ZERO_I,
  input wire logic EMULATOR_FLOAT_PIN_N_I
);
  import dxbus_pkg::*;

  // ************************************************************
  // Access sequencer
  // ************************************************************
  dxbus_state_t state_ff, nxt_state;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic write_ff;
  dxbus_space_t space_ff;
  logic [WAIT_W-1:0] wait_cnt_ff;
  logic rsp_valid_ff;
  logic [WAIT_W-1:0] cfg_count;

  wire logic req_take = (state_ff == DXBUS_ST_IDLE) && REQ_VALID_I;
  wire logic in_cycle = (state_ff == DXBUS_ST_WAIT) || (state_ff == DXBUS_ST_READY);
  wire logic wait_done = (wait_cnt_ff == '0);
  wire logic finish = (state_ff == DXBUS_ST_READY) && READY_I;
  // Global data space is data space restricted to the upper 32K words.
  wire logic [ADDR_W-1:0] eff_addr = (REQ_SPACE_I == DXBUS_SP_GLOBAL)
                                     ? (REQ_ADDR_I | (ADDR_W'(1) << `DXBUS_GLOBAL_MSB))
                                     : REQ_ADDR_I;
  // Float needs test reset low, emulator pin zero high and the float pin low.
  wire logic float_all = !TEST_RESET_I && EMULATOR_PIN_ZERO_I && !EMULATOR_FLOAT_PIN_N_I;
  // The lookup follows the incoming request on the take edge, so the new space's count is ready in setup.
  // Steering it from the stored space alone would hand setup the count of the previous access.
  wire dxbus_space_t lookup_space = req_take ? REQ_SPACE_I : space_ff;

  dxbus_waitcfg #(
    .WAIT_W(WAIT_W)
  ) u_waitcfg (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESETN_I),
    .wr_en_i(WAIT_WR_I),
    .wr_space_i(WAIT_SPACE_I),
    .wr_count_i(WAIT_COUNT_I),
    .rd_space_i(lookup_space),
    .rd_count_o(cfg_count)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DXBUS_ST_IDLE: begin
        if (REQ_VALID_I) begin
          nxt_state = DXBUS_ST_SETUP;
        end
      end
      DXBUS_ST_SETUP: nxt_state = DXBUS_ST_WAIT;
      DXBUS_ST_WAIT: begin
        if (wait_done) begin
          nxt_state = DXBUS_ST_READY;
        end
      end
      DXBUS_ST_READY: begin
        if (READY_I) begin
          nxt_state = DXBUS_ST_HOLD;
        end
      end
      DXBUS_ST_HOLD: nxt_state = DXBUS_ST_IDLE;
      default: nxt_state = DXBUS_ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_ff <= DXBUS_ST_IDLE;
      addr_ff <= `DXBUS_ADDR_RST;
      wdata_ff <= `DXBUS_DATA_RST;
      rdata_ff <= `DXBUS_DATA_RST;
      write_ff <= 1'b0;
      space_ff <= DXBUS_SP_PROG;
      wait_cnt_ff <= '0;
      rsp_valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rsp_valid_ff <= finish;
      if (req_take) begin
        addr_ff <= eff_addr;
        wdata_ff <= REQ_WDATA_I;
        write_ff <= REQ_WRITE_I;
        space_ff <= REQ_SPACE_I;
      end
      // The configuration lookup lands during setup, so the count loads there.
      if (state_ff == DXBUS_ST_SETUP) begin
        wait_cnt_ff <= cfg_count;
      end else if (state_ff == DXBUS_ST_WAIT && !wait_done) begin
        wait_cnt_ff <= wait_cnt_ff - WAIT_W'(1);
      end
      if (finish && !write_ff) begin
        rdata_ff <= DATA_BUS_I;
      end
    end
  end

  // ************************************************************
  // Pin drive
  // ************************************************************
  wire logic sel_prog = in_cycle && (space_ff == DXBUS_SP_PROG);
  wire logic sel_data = in_cycle && (space_ff == DXBUS_SP_DATA || space_ff == DXBUS_SP_GLOBAL);
  wire logic sel_io = in_cycle && (space_ff == DXBUS_SP_IO);

  assign REQ_READY_O = (state_ff == DXBUS_ST_IDLE);
  assign RSP_VALID_O = rsp_valid_ff;
  assign RSP_RDATA_O = rdata_ff;
  assign ADDRESS_BUS_O = addr_ff;
  assign ADDRESS_BUS_OE_O = !float_all;
  assign CONTROL_OE_O = !float_all;
  assign DATA_BUS_O = wdata_ff;
  // Write data is driven from setup to hold so it brackets the write strobe on both sides.
  assign DATA_BUS_OE_O = RESETN_I && !float_all && write_ff && (state_ff != DXBUS_ST_IDLE);
  assign PROGRAM_SPACE_SELECT_N_O = !sel_prog;
  assign DATA_SPACE_SELECT_N_O = !sel_data;
  assign IO_SPACE_SELECT_N_O = !sel_io;
  assign BUS_CYCLE_STROBE_N_O = !in_cycle;
  assign READ_WRITE_O = !(write_ff && state_ff != DXBUS_ST_IDLE);
  assign READ_STROBE_N_O = !(in_cycle && !write_ff);
  assign WRITE_STROBE_N_O = !(in_cycle && write_ff);

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_stall;
    (state_ff == DXBUS_ST_READY) && !READY_I;
  endsequence

  sequence s_wait_entry;
    (state_ff == DXBUS_ST_SETUP) ##1 (state_ff == DXBUS_ST_WAIT);
  endsequence

  AST_ONE_SELECT: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
    $onehot0({PROGRAM_SPACE_SELECT_N_O, DATA_SPACE_SELECT_N_O, IO_SPACE_SELECT_N_O} ^ 3'h7))
    else $error("More than one space select active.");
  AST_ADDR_STABLE: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
    (!BUS_CYCLE_STROBE_N_O && $past(!BUS_CYCLE_STROBE_N_O)) |-> $stable(ADDRESS_BUS_O))
    else $error("Address moved during strobe.");
  AST_READY_WAIT: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
    s_stall |=> (state_ff == DXBUS_ST_READY) && !BUS_CYCLE_STROBE_N_O)
    else $error("Access ended while ready low.");
  AST_READY_DONE: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
    finish |=> RSP_VALID_O && BUS_CYCLE_STROBE_N_O)
    else $error("Ready high did not complete access.");
  AST_WAIT_LEN: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
    s_wait_entry |-> ##[1:8] (state_ff == DXBUS_ST_READY))
    else $error("Wait states not bounded by seven.");
  AST_DATA_FLOAT: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
    READ_WRITE_O |-> !DATA_BUS_OE_O)
    else $error("Data bus driven while direction shows read.");
  AST_STROBES: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
    !(READ_STROBE_N_O == 1'b0 && WRITE_STROBE_N_O == 1'b0) && (READ_STROBE_N_O && WRITE_STROBE_N_O) == BUS_CYCLE_STROBE_N_O)
    else $error("Read and write strobes inconsistent.");
  AST_WRITE_DIR: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
    !WRITE_STROBE_N_O |-> (!READ_WRITE_O && DATA_BUS_OE_O) || float_all)
    else $error("Write strobe without driven data.");
  AST_FLOAT: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
    float_all |-> !ADDRESS_BUS_OE_O && !CONTROL_OE_O && !DATA_BUS_OE_O)
    else $error("Outputs driven during float.");
endmodule // dxbus_master
`default_nettype wire

// ### tb/dxbus_mem_model.sv
// Far-side memory model of the external bus, with programmable ready stretching.
`default_nettype none
module dxbus_mem_model (
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  input wire logic prog_n_i,
  input wire logic io_n_i,
  input wire logic cyc_n_i,
  input wire logic rd_n_i,
  input wire logic we_n_i,
  input wire logic [7:0] low_i,
  output logic ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // A released bus shows the inverse of its last level, so a late sample cannot match by chance.
  // ****************************************
  logic [15:0] mem [0:511];
  logic [15:0] last_ff;
  logic [8:0] key_ff;
  logic [7:0] cnt_ff;
  wire logic [8:0] key;
  assign key = {io_n_i ? {1'b0, prog_n_i} : 2'h2, addr_i[15], addr_i[5:0]};
  // The first ready sample already sees the count one past the wait states, and ready waits for the count to pass low_i,
  // so the ready-low samples that follow number low_i minus the wait states.
  assign ready_o = cyc_n_i | (cnt_ff > low_i);
  assign dq_o = (!rd_n_i && !cyc_n_i) ? mem[key] : ~last_ff;
  always_ff @(posedge clk_i) begin
    cnt_ff <= cyc_n_i ? 8'h00 : cnt_ff + 8'h01;
    last_ff <= dq_i;
    if (!we_n_i) begin
      key_ff <= key;
    end
  end
  always @(posedge we_n_i) begin
    mem[key_ff] = dq_i;
  end
endmodule // dxbus_mem_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of the external bus master against the far-side memory model.
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dxbus_pkg::*;
  typedef struct packed {logic wr; dxbus_space_t sp; logic [15:0] a; logic [15:0] d; logic [7:0] st;} dxbus_tb_row_t;
  logic clk = 1'b0, rst_n = 1'b0, wait_wr = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic trst = 1'b0, emu_zero = 1'b0, float_n = 1'b1, rdy, rd_n, we_n, cyc_n, prog_n, io_n, data_n, rw;
  logic rdy_o, rsp_v, aoe, doe, coe;
  dxbus_space_t wait_space = DXBUS_SP_PROG, req_space = DXBUS_SP_PROG;
  logic [2:0] wait_count = 3'h0;
  logic [7:0] low = 8'h00;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, rdata, abus, dout, mdq;
  wire logic [15:0] dbus;
  int error_cnt = 0, compares = 0, lat;
  logic [2:0] wt [4] = '{3'h0, 3'h7, 3'h3, 3'h1};
  dxbus_tb_row_t rows [9] = '{
    '{1'b1, DXBUS_SP_PROG, 16'h0001, 16'hA5A5, 8'h00}, '{1'b1, DXBUS_SP_DATA, 16'h1234, 16'h5A5A, 8'h02},
    '{1'b1, DXBUS_SP_IO, 16'hFFFF, 16'h8001, 8'h00}, '{1'b1, DXBUS_SP_GLOBAL, 16'h0034, 16'h0F0F, 8'h01},
    '{1'b0, DXBUS_SP_PROG, 16'h0001, 16'hA5A5, 8'h01}, '{1'b0, DXBUS_SP_DATA, 16'h1234, 16'h5A5A, 8'h00},
    '{1'b0, DXBUS_SP_IO, 16'hFFFF, 16'h8001, 8'h03}, '{1'b0, DXBUS_SP_DATA, 16'h8034, 16'h0F0F, 8'h00},
    '{1'b0, DXBUS_SP_GLOBAL, 16'h0034, 16'h0F0F, 8'h00}};
  assign dbus = doe ? dout : mdq;
  always #12.5 clk = ~clk;
  dxbus_master u_dxbus_master (.REF_CLK_I(clk), .RESETN_I(rst_n), .WAIT_WR_I(wait_wr), .WAIT_SPACE_I(wait_space),
    .WAIT_COUNT_I(wait_count), .REQ_VALID_I(req_valid), .REQ_READY_O(rdy_o), .REQ_WRITE_I(req_write),
    .REQ_SPACE_I(req_space), .REQ_ADDR_I(req_addr), .REQ_WDATA_I(req_wdata), .RSP_VALID_O(rsp_v),
    .RSP_RDATA_O(rdata), .ADDRESS_BUS_O(abus), .ADDRESS_BUS_OE_O(aoe), .DATA_BUS_I(dbus), .DATA_BUS_O(dout),
    .DATA_BUS_OE_O(doe), .PROGRAM_SPACE_SELECT_N_O(prog_n), .DATA_SPACE_SELECT_N_O(data_n),
    .IO_SPACE_SELECT_N_O(io_n), .BUS_CYCLE_STROBE_N_O(cyc_n), .READ_WRITE_O(rw), .READ_STROBE_N_O(rd_n),
    .WRITE_STROBE_N_O(we_n), .CONTROL_OE_O(coe), .READY_I(rdy), .TEST_RESET_I(trst),
    .EMULATOR_PIN_ZERO_I(emu_zero), .EMULATOR_FLOAT_PIN_N_I(float_n));
  dxbus_mem_model u_dxbus_mem_model (.clk_i(clk), .addr_i(abus), .dq_i(dbus), .dq_o(mdq), .prog_n_i(prog_n),
    .io_n_i(io_n), .cyc_n_i(cyc_n), .rd_n_i(rd_n), .we_n_i(we_n), .low_i(low), .ready_o(rdy));
  // ****************************************
  // Bus access tasks.
  // ****************************************
  task automatic stop_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #2;
  endtask
  task automatic acc(input dxbus_tb_row_t r);
    logic [2:0] sel;
    logic [15:0] ea;
    sel = (r.sp == DXBUS_SP_PROG) ? 3'h3 : (r.sp == DXBUS_SP_IO) ? 3'h6 : 3'h5;
    ea = (r.sp == DXBUS_SP_GLOBAL) ? (r.a | 16'h8000) : r.a;
    low = wt[r.sp] + r.st;
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, r.wr, r.a, r.d};
    req_space = r.sp;
    `CHK("req_ready", 1'b1, rdy_o)
    @(posedge clk);
    #2 req_valid = 1'b0;
    for (lat = 1; lat <= 30; lat++) begin
      if (lat > 1) @(posedge clk);
      #1;
      if (lat == 1) `CHK("busy", 1'b0, rdy_o)
      if (lat == 2) begin
        `CHK("selects", sel, {prog_n, data_n, io_n})
        `CHK("address", ea, abus)
        `CHK("strobes", {1'b0, !r.wr, r.wr, !r.wr}, {cyc_n, rw, rd_n, we_n})
        `CHK("data_oe", r.wr, doe)
        if (r.wr) `CHK("data_out", r.d, dout)
      end
      if (rsp_v) break;
    end
    if (!rsp_v) begin
      error_cnt++;
      stop_test();
    end
    `CHK("latency", 4 + wt[r.sp] + r.st, lat)
    `CHK("released", 6'h3F, {prog_n, data_n, io_n, cyc_n, rd_n, we_n})
    if (!r.wr) `CHK("read_data", r.d, rdata)
  endtask
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    #1 `CHK("reset_pins", 8'hFE, {prog_n, data_n, io_n, cyc_n, rw, rd_n, we_n, doe})
    #1 rst_n = 1'b1;
    for (int s = 0; s < 4; s++) begin
      step();
      {wait_wr, wait_count} = {1'b1, wt[s]};
      wait_space = dxbus_space_t'(s);
    end
    step();
    wait_wr = 1'b0;
    foreach (rows[i]) begin
      step();
      acc(rows[i]);
    end
    for (int i = 0; i < 8; i++) begin
      step();
      {trst, emu_zero, float_n} = 3'(i);
      #1 `CHK("float", (i == 2) ? 3'h0 : 3'h6, {aoe, coe, doe})
    end
    step();
    {trst, emu_zero, float_n, low} = {3'h1, 8'h09};
    {req_valid, req_write, req_addr, req_wdata} = {2'h3, 16'h0002, 16'h1111};
    req_space = DXBUS_SP_PROG;
    step();
    req_valid = 1'b0;
    repeat (2) step();
    rst_n = 1'b0;
    #1 `CHK("abort", 8'hFE, {prog_n, data_n, io_n, cyc_n, rw, rd_n, we_n, doe})
    step();
    rst_n = 1'b1;
    step();
    acc(rows[4]);
    stop_test();
  end
endmodule // tb
`default_nettype wire
